// ===== pca_pwm_cycle_config.sv
// Shared PWM cycle length, cycle overflow flag and reload bank select
//
// How it works
// - Reload bank select high steers compare addresses to auto-reload registers.
// - Auto-reload values only feed channels running 9, 10 or 11-bit PWM.
// - Overflow interrupt requested while flag set and enable set, else none.
// - Flag set when main counter overflows at selected 8th to 11th bit.
// - Flag set by hardware or software one; only software clears it.
// - Bits 4 to 2 read zero and ignore writes.
// - Select code 00 is 8 bits, 01 is 9, 11 is 11.
// - Chosen length applies at once to all non-wide PWM channels.
// - Wide PWM channels ignore the cycle length select.
// - Wide PWM enable picks 16-bit only while channel PWM mode is on.
`timescale 1ns/10ps
`include "pwm_cycle_defs.svh"

module pca_pwm_cycle_config #(
  parameter int CHANNELS = 6
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register access
  input wire pwm_cycle_pkg::sfr_req_type i_sfr,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  // Main counter value
  input wire logic [15:0] i_main_array_counter,
  // Per channel mode
  input wire logic [CHANNELS-1:0] i_pwm_mode_enable,
  input wire logic [CHANNELS-1:0] i_wide_pwm_enable,
  // Channel address steering
  output logic o_access_reload_bank,
  // Per channel reload use and cycle width
  output logic [CHANNELS-1:0] o_reload_active,
  output logic [CHANNELS-1:0] o_wide_pwm_active,
  output logic [3:0] o_cycle_bits,
  output logic o_cycle_overflow_pulse,
  // Interrupt request to the counter array
  output logic o_cycle_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [15:0] cnt_prev_reg;
  logic [15:0] cnt_prev_next;
  logic cfg_write;
  logic ovf_event;
  logic [1:0] len_sel;
  logic [3:0] cycle_bits;
  logic [15:0] wrap_mask;

  assign cfg_write = i_sfr.wr && (i_sfr.addr == `PWM_CYCLE_CFG_ADDR);
  assign len_sel = cfg_reg[`CYCLE_LEN_MSB:`CYCLE_LEN_LSB];

  // Cycle width from select code
  always_comb begin
    case (pwm_cycle_pkg::cycle_length_type'(len_sel))
      pwm_cycle_pkg::LEN_8BIT: cycle_bits = 4'h8;
      pwm_cycle_pkg::LEN_9BIT: cycle_bits = 4'h9;
      pwm_cycle_pkg::LEN_10BIT: cycle_bits = 4'hA;
      default: cycle_bits = 4'hB;
    endcase
  end

  // Low counter bits that wrap at the selected cycle length
  always_comb begin
    case (pwm_cycle_pkg::cycle_length_type'(len_sel))
      pwm_cycle_pkg::LEN_8BIT: wrap_mask = 16'h00FF;
      pwm_cycle_pkg::LEN_9BIT: wrap_mask = 16'h01FF;
      pwm_cycle_pkg::LEN_10BIT: wrap_mask = 16'h03FF;
      default: wrap_mask = 16'h07FF;
    endcase
  end

  // Overflow seen when the selected low bits go from all ones to zero
  assign ovf_event = ((cnt_prev_reg & wrap_mask) == wrap_mask) &&
    ((i_main_array_counter & wrap_mask) == 16'h0000) &&
    (cnt_prev_reg != i_main_array_counter);

  // Next register value; hardware set wins over software clear
  always_comb begin
    cfg_next = cfg_reg;
    cnt_prev_next = i_main_array_counter;
    if (cfg_write) begin
      cfg_next = i_sfr.wdata & `CYCLE_WRITE_MASK;
    end
    if (ovf_event) begin
      cfg_next[`CYCLE_OVF_FLAG_BIT] = 1'b1;
    end
    cfg_next[4:2] = 3'h0;
  end

  // Register stage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg <= `PWM_CYCLE_CFG_RESET;
      cnt_prev_reg <= 16'h0000;
    end else begin
      cfg_reg <= cfg_next;
      cnt_prev_reg <= cnt_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read data and hit
  always_comb begin
    o_sfr_hit = 1'b0;
    o_sfr_rdata = 8'h00;
    if (i_sfr.addr == `PWM_CYCLE_CFG_ADDR) begin
      o_sfr_hit = 1'b1;
      o_sfr_rdata = cfg_reg;
    end
  end

  // Decoded configuration outputs
  assign o_access_reload_bank = cfg_reg[`RELOAD_BANK_SELECT_BIT];
  assign o_cycle_bits = cycle_bits;
  assign o_cycle_overflow_pulse = ovf_event;
  assign o_cycle_irq = cfg_reg[`CYCLE_OVF_IRQ_EN_BIT] &&
    cfg_reg[`CYCLE_OVF_FLAG_BIT];

  // Per channel mode resolution
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      o_wide_pwm_active[i] = i_pwm_mode_enable[i] &&
        i_wide_pwm_enable[i];
      o_reload_active[i] = i_pwm_mode_enable[i] &&
        !i_wide_pwm_enable[i] && (cycle_bits != 4'h8);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // One cycle in which the selected low counter bits wrap
  sequence wrap_s;
    ovf_event;
  endsequence

  // Wrap in the same cycle as a write that clears the flag
  sequence race_s;
    ovf_event && cfg_write && !i_sfr.wdata[`CYCLE_OVF_FLAG_BIT];
  endsequence

  // Flag set by hardware or software, held until software clears it
  flag_set_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wrap_s |=> cfg_reg[`CYCLE_OVF_FLAG_BIT])
    else $error("overflow did not set flag");

  flag_sticky_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_reg[`CYCLE_OVF_FLAG_BIT] && !cfg_write |=>
    cfg_reg[`CYCLE_OVF_FLAG_BIT])
    else $error("flag cleared without write");

  sw_set_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && i_sfr.wdata[5] |=> cfg_reg[`CYCLE_OVF_FLAG_BIT])
    else $error("software set lost");

  set_wins_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    race_s |=> cfg_reg[`CYCLE_OVF_FLAG_BIT])
    else $error("clear write beat hardware set");

  sw_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && !i_sfr.wdata[`CYCLE_OVF_FLAG_BIT] && !ovf_event |=>
    !cfg_reg[`CYCLE_OVF_FLAG_BIT])
    else $error("software clear lost");

  // Interrupt request against enable and flag
  irq_gate_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && i_sfr.wdata[`CYCLE_OVF_IRQ_EN_BIT] &&
    i_sfr.wdata[`CYCLE_OVF_FLAG_BIT] |=> o_cycle_irq)
    else $error("irq missing with flag and enable");

  irq_off_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && !i_sfr.wdata[`CYCLE_OVF_IRQ_EN_BIT] |=> !o_cycle_irq)
    else $error("irq raised with enable clear");

  // Unused bits neither stored nor read back
  unused_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write |=> o_sfr_rdata[4:2] == 3'h0 || !o_sfr_hit)
    else $error("unused bits not zero");

  unused_reg_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_reg[4:2] == 3'h0)
    else $error("unused bits stored");

  // Cycle length decode of written codes
  len_eight_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && i_sfr.wdata[1:0] == 2'h0 |=> o_cycle_bits == 4'h8)
    else $error("code 00 not eight bits");

  len_code_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && i_sfr.wdata[1:0] == 2'h2 |=> o_cycle_bits == 4'hA)
    else $error("code 10 not ten bits");

  len_eleven_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write && i_sfr.wdata[1:0] == 2'h3 |=> o_cycle_bits == 4'hB)
    else $error("code 11 not eleven bits");

  // Compare address steering
  bank_sel_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    cfg_write |=> o_access_reload_bank == $past(i_sfr.wdata[7]))
    else $error("bank select not taken");

  // Per channel reload use and wide mode
  wide_ignore_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wide_pwm_enable & o_reload_active) == '0)
    else $error("wide channel uses reload");

  reload_len_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_cycle_bits == 4'h8 |-> o_reload_active == '0)
    else $error("reload used in eight bit cycle");

  wide_mode_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_wide_pwm_active & ~i_pwm_mode_enable) == '0)
    else $error("wide mode active without pwm mode");

endmodule : pca_pwm_cycle_config

// ===== pwm_cycle_defs.svh
// Offsets, field positions and reset values of the PWM cycle register
`ifndef PWM_CYCLE_DEFS_SVH
`define PWM_CYCLE_DEFS_SVH
`define PWM_CYCLE_CFG_ADDR 8'hDF
`define PWM_CYCLE_CFG_RESET 8'h00
`define RELOAD_BANK_SELECT_BIT 7
`define CYCLE_OVF_IRQ_EN_BIT 6
`define CYCLE_OVF_FLAG_BIT 5
`define CYCLE_LEN_MSB 1
`define CYCLE_LEN_LSB 0
`define CYCLE_WRITE_MASK 8'hE3
`endif

// ===== pwm_cycle_pkg.sv
// Types shared by the PWM cycle configuration block
package pwm_cycle_pkg;
  typedef enum logic [1:0] {
    LEN_8BIT,
    LEN_9BIT,
    LEN_10BIT,
    LEN_11BIT
  } cycle_length_type;

  // Register bus request from the CPU special-function-register space
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  // Decoded configuration fields
  typedef struct packed {
    logic reload_bank_select;
    logic cycle_overflow_irq_enable;
    logic cycle_overflow_flag;
    cycle_length_type cycle_length_select;
  } pwm_cfg_type;
endpackage : pwm_cycle_pkg

// ===== testbench.sv
// Self-checking bench for the shared PWM cycle configuration register
`timescale 1ns/10ps
`include "pwm_cycle_defs.svh"

module testbench;
  logic i_clk;
  logic i_rst_b;
  pwm_cycle_pkg::sfr_req_type i_sfr;
  logic [7:0] o_sfr_rdata;
  logic o_sfr_hit;
  logic [15:0] i_main_array_counter;
  logic [5:0] i_pwm_mode_enable;
  logic [5:0] i_wide_pwm_enable;
  logic o_access_reload_bank;
  logic [5:0] o_reload_active;
  logic [5:0] o_wide_pwm_active;
  logic [3:0] o_cycle_bits;
  logic o_cycle_overflow_pulse;
  logic o_cycle_irq;
  int fails = 0;
  int n_tests = 0;

  pca_pwm_cycle_config #(.CHANNELS(6)) i_dut (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_main_array_counter(i_main_array_counter),
    .i_pwm_mode_enable(i_pwm_mode_enable),
    .i_wide_pwm_enable(i_wide_pwm_enable),
    .o_access_reload_bank(o_access_reload_bank),
    .o_reload_active(o_reload_active),
    .o_wide_pwm_active(o_wide_pwm_active), .o_cycle_bits(o_cycle_bits),
    .o_cycle_overflow_pulse(o_cycle_overflow_pulse),
    .o_cycle_irq(o_cycle_irq));

  ////////////////////////////////////////////////////////////////////////
  // Clock, common tasks
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic step();
    @(posedge i_clk);
    #1;
  endtask : step

  // Byte compare with mismatch report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle register write, address left on the register
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    i_sfr = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    step();
    i_sfr.wr = 1'b0;
    i_sfr.addr = `PWM_CYCLE_CFG_ADDR;
    #1;
  endtask : wr

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic fields_and_modes();
    chk(o_sfr_rdata, 8'h00);
    chk({7'h00, o_sfr_hit}, 8'h01);
    wr(8'hDF, 8'hFF);
    chk(o_sfr_rdata, 8'hE3);
    chk({7'h00, o_access_reload_bank}, 8'h01);
    chk({7'h00, o_cycle_irq}, 8'h01);
    wr(8'hDE, 8'h00);
    chk(o_sfr_rdata, 8'hE3);
    for (int c = 0; c < 4; c++) begin
      wr(8'hDF, 8'(c));
      chk({4'h0, o_cycle_bits}, 8'(8 + c));
      chk({2'h0, o_reload_active}, (c != 0) ? 8'h1C : 8'h00);
      chk({2'h0, o_wide_pwm_active}, 8'h03);
    end
    chk({7'h00, o_access_reload_bank}, 8'h00);
  endtask : fields_and_modes

  task automatic overflow_flag();
    for (int c = 0; c < 4; c++) begin
      i_main_array_counter = 16'((1 << (8 + c)) - 1);
      step();
      wr(8'hDF, 8'(c));
      i_main_array_counter = 16'(1 << (8 + c));
      step();
      step();
      chk(o_sfr_rdata, 8'(8'h20 | c));
      chk({7'h00, o_cycle_irq}, 8'h00);
    end
    wr(8'hDF, 8'h03);
    i_main_array_counter = 16'h00FF;
    step();
    i_main_array_counter = 16'h0100;
    step();
    step();
    chk(o_sfr_rdata, 8'h03);
    wr(8'hDF, 8'h20);
    chk(o_sfr_rdata, 8'h20);
    wr(8'hDF, 8'h60);
    chk({7'h00, o_cycle_irq}, 8'h01);
    wr(8'hDF, 8'h40);
    chk({7'h00, o_cycle_irq}, 8'h00);
  endtask : overflow_flag

  // Overflow racing a clearing write, then a reset in mid-run
  task automatic race_and_reset();
    wr(8'hDF, 8'h00);
    i_main_array_counter = 16'h00FF;
    step();
    i_main_array_counter = 16'h0100;
    #1;
    chk({7'h00, o_cycle_overflow_pulse}, 8'h01);
    wr(8'hDF, 8'h00);
    chk(o_sfr_rdata, 8'h20);
    chk({7'h00, o_cycle_overflow_pulse}, 8'h00);
    wr(8'hDF, 8'hE3);
    i_rst_b = 1'b0;
    #1;
    chk(o_sfr_rdata, 8'h00);
    chk({7'h00, o_cycle_irq}, 8'h00);
    chk({4'h0, o_cycle_bits}, 8'h08);
    chk({7'h00, o_access_reload_bank}, 8'h00);
    step();
    i_rst_b = 1'b1;
    wr(8'hDF, 8'h62);
    chk(o_sfr_rdata, 8'h62);
    chk({4'h0, o_cycle_bits}, 8'h0A);
    chk({7'h00, o_cycle_irq}, 8'h01);
    chk({2'h0, o_reload_active}, 8'h1C);
  endtask : race_and_reset

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst_b = 1'b0;
    i_sfr = '{wr: 1'b0, rd: 1'b0, addr: 8'hDF, wdata: 8'h00};
    i_main_array_counter = 16'h0000;
    i_pwm_mode_enable = 6'h1F;
    i_wide_pwm_enable = 6'h23;
    repeat (10) @(posedge i_clk);
    #1;
    i_rst_b = 1'b1;
    fields_and_modes();
    overflow_flag();
    race_and_reset();
    final_report();
  end
endmodule : testbench
